// >>> design/swtc_pkg.sv
// swtc_pkg: constants shared by the reference window and trigger clock block.
// assumes one device clock (sys_clk, 25 MHz) drives all of the logic.
package swtc_pkg;
	localparam int MAP_W        = 16;
	localparam int SEL_W        = 4;
	localparam int DIV_W        = 8;
	localparam int TONE_W       = 4;
	localparam int ALARM_W      = 7;

	// ends of the position map are always flagged
	localparam logic [MAP_W-1:0] MAP_ENDS = 16'h8001;
	localparam logic [MAP_W-1:0] MAP_RESET = 16'h8001;
	localparam int MAP_LO       = 0;
	localparam int MAP_HI       = 15;

	// alarm bit positions in the alarm status word
	localparam int ALM_FIFO_EMPTY  = 0;
	localparam int ALM_FIFO_FULL   = 1;
	localparam int ALM_LVDS_CLK    = 2;
	localparam int ALM_LVDS_STROBE = 3;
	localparam int ALM_TRIG_ALIGN  = 4;
	localparam int ALM_DIV_ALIGN   = 5;
	localparam int ALM_CLK_ALIGN   = 6;
	localparam logic [ALARM_W-1:0] ALARM_RESET = 7'h00;

	// main clock divider ratio and divider phase after a reference edge
	localparam logic [DIV_W-1:0] MAIN_DIV_RESET  = 8'h08;
	localparam logic [DIV_W-1:0] DIV_PHASE_ZERO  = 8'h00;
	localparam logic [DIV_W-1:0] TRIGGER_DIVIDE_RATIO_RESET  = 8'h01;
	localparam logic [TONE_W-1:0] TONE_RESET     = 4'h0;
endpackage

// >>> design/swtc_sync3.sv
// swtc_sync3: three-stage synchroniser for pin inputs, per bit.
// assumes inputs are asynchronous; output follows once stages two and three agree.
`timescale 1ns/100ps
module swtc_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit moves only where stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync_out <= '0;
		end else begin
			sync_out <= (stage2 & ~(stage2 ^ stage3)) | (sync_out & (stage2 ^ stage3));
		end
	end
endmodule

// >>> design/swtc_alarm_flags.sv
// swtc_alarm_flags: sticky alarm word, write-one-to-clear.
// assumes set pulses and clear strobe come from logic on sys_clk.
`timescale 1ns/100ps
module swtc_alarm_flags
	import swtc_pkg::*;
#(
	parameter int WIDTH = ALARM_W
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] alarm_set,
	input  wire logic             clear_write,
	input  wire logic [WIDTH-1:0] clear_data,
	output logic      [WIDTH-1:0] alarm_flags
);
	logic [WIDTH-1:0] clear_mask;

	assign clear_mask = clear_write ? clear_data : '0;

	// a set in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alarm_flags <= ALARM_RESET[WIDTH-1:0];
		end else begin
			alarm_flags <= (alarm_flags & ~clear_mask) | alarm_set;
		end
	end
endmodule

// >>> design/swtc_top.sv
// swtc_top: reference position detector, capture select, trigger divider, alarms.
// assumes the analog delay lines deliver 16 reference taps (coarse and fine) as pins,
// and that configuration fields arrive as quasi-static ports.
`timescale 1ns/100ps
module swtc_top
	import swtc_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire logic [MAP_W-1:0]   coarse_taps,
	input  wire logic [MAP_W-1:0]   fine_taps,
	input  wire logic               fine_step_select,
	input  wire logic               ref_receiver_sleep,
	input  wire logic               ref_processing_enable,
	input  wire logic               persistence_enable,
	input  wire logic               align_enable,
	input  wire logic [SEL_W-1:0]   capture_select,
	input  wire logic [DIV_W-1:0]   trigger_divide_ratio,
	input  wire logic               trigger_output_enable,
	input  wire logic               oscillator_enable,
	input  wire logic [TONE_W-1:0]  tone_select_input,
	input  wire logic               bank_select_input,
	input  wire logic               fifo_empty_event,
	input  wire logic               fifo_full_event,
	input  wire logic               lvds_clock_event,
	input  wire logic               lvds_strobe_event,
	input  wire logic [ALARM_W-1:0] alarm_pin_mask,
	input  wire logic               mute_on_alarm,
	input  wire logic               alarm_clear_write,
	input  wire logic [ALARM_W-1:0] alarm_clear_data,
	output logic      [MAP_W-1:0]   ref_edge_position_map,
	output logic      [ALARM_W-1:0] system_alarm_status,
	output logic                    alarm_pin,
	output logic                    output_mute,
	output logic                    trigger_clock_out,
	output logic      [TONE_W-1:0]  tone_select_a,
	output logic      [TONE_W-1:0]  tone_select_b,
	output logic                    bank_select_a,
	output logic                    bank_select_b
);
	logic [MAP_W-1:0]   tap_raw;
	logic [MAP_W-1:0]   taps;
	logic [MAP_W-1:0]   taps_prev;
	logic               ref_live;
	logic               taps_fresh;
	logic               captured;
	logic               captured_prev;
	logic               cap_edge;
	logic               persist_prev;
	logic [DIV_W-1:0]   main_cnt;
	logic [DIV_W-1:0]   trig_cnt;
	logic [DIV_W-1:0]   trig_ratio;
	logic [DIV_W-1:0]   trig_half;
	logic               trig_rise;
	logic               main_shift;
	logic               trig_shift;
	logic [ALARM_W-1:0] alarm_set;
	logic [TONE_W:0]    pin_raw;
	logic [TONE_W:0]    pin_sync;
	logic [TONE_W:0]    pin_sample;
	logic               sample_tick;

	// flags a position whose neighbour differs, ends forced high
	function automatic logic [MAP_W-1:0] risk_map(input logic [MAP_W-1:0] t);
		logic [MAP_W-1:0] r;
		r = MAP_ENDS;
		for (int i = 1; i < MAP_W - 1; i++) begin
			r[i] = (t[i] != t[i-1]) || (t[i] != t[i+1]);
		end
		return r;
	endfunction

	// true on the last count, where the divider wraps to zero on its own
	function automatic logic at_wrap(input logic [DIV_W-1:0] c, input logic [DIV_W-1:0] q);
		return c >= q - 1'b1;
	endfunction

	// tap set chosen before the synchroniser; the select is static in use
	assign tap_raw = fine_step_select ? fine_taps : coarse_taps;

	swtc_sync3 #(
		.WIDTH(MAP_W)
	) u_tap_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.async_in(tap_raw),
		.sync_out(taps)
	);

	assign pin_raw = {bank_select_input, tone_select_input};

	swtc_sync3 #(
		.WIDTH(TONE_W + 1)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.async_in(pin_raw),
		.sync_out(pin_sync)
	);

	assign ref_live   = ref_processing_enable && !ref_receiver_sleep;
	assign taps_fresh = ref_live && (taps != '0) && (taps_prev == '0);
	assign captured   = taps[capture_select];
	assign cap_edge   = ref_live && captured && !captured_prev;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			taps_prev     <= '0;
			captured_prev <= 1'b0;
			persist_prev  <= 1'b0;
		end else begin
			taps_prev     <= taps;
			captured_prev <= captured;
			persist_prev  <= persistence_enable;
		end
	end

	// position map: restart on persistence rise, else accumulate or replace
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ref_edge_position_map <= MAP_RESET;
		end else if (persistence_enable && !persist_prev) begin
			ref_edge_position_map <= MAP_ENDS;
		end else if (taps_fresh && persistence_enable) begin
			ref_edge_position_map <= ref_edge_position_map | risk_map(taps);
		end else if (taps_fresh) begin
			ref_edge_position_map <= risk_map(taps);
		end
	end

	// divider ratio 0 behaves as 1 so the counter always wraps
	assign trig_ratio = (trigger_divide_ratio == '0) ? TRIGGER_DIVIDE_RATIO_RESET : trigger_divide_ratio;
	assign trig_half  = DIV_W'(({1'b0, trig_ratio} + 1'b1) >> 1);
	// an edge on the wrap count repeats the natural wrap, so it is no shift
	assign main_shift = cap_edge && align_enable && !at_wrap(main_cnt, MAIN_DIV_RESET);
	// trigger flag held off when the main divider moved it
	assign trig_shift = cap_edge && !at_wrap(trig_cnt, trig_ratio) && !main_shift;
	assign trig_rise  = (trig_cnt == DIV_PHASE_ZERO);

	// main divider only realigns while alignment is enabled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			main_cnt <= DIV_PHASE_ZERO;
		end else if (cap_edge && align_enable) begin
			main_cnt <= DIV_PHASE_ZERO;
		end else if (at_wrap(main_cnt, MAIN_DIV_RESET)) begin
			main_cnt <= DIV_PHASE_ZERO;
		end else begin
			main_cnt <= main_cnt + 1'b1;
		end
	end

	// trigger divider follows every edge, align enable or not
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trig_cnt <= DIV_PHASE_ZERO;
		end else if (cap_edge) begin
			trig_cnt <= DIV_PHASE_ZERO;
		end else if (at_wrap(trig_cnt, trig_ratio)) begin
			trig_cnt <= DIV_PHASE_ZERO;
		end else begin
			trig_cnt <= trig_cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trigger_clock_out <= 1'b0;
		end else begin
			trigger_clock_out <= (trig_cnt < trig_half) && trigger_output_enable
				&& oscillator_enable;
		end
	end

	// pins sampled on each trigger rise regardless of the output enable
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_sample  <= '0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= trig_rise;
			if (trig_rise) begin
				pin_sample <= pin_sync;
			end
		end
	end

	// one cycle after the sample, both channels together
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tone_select_a <= TONE_RESET;
			tone_select_b <= TONE_RESET;
			bank_select_a <= 1'b0;
			bank_select_b <= 1'b0;
		end else if (sample_tick) begin
			tone_select_a <= pin_sample[TONE_W-1:0];
			tone_select_b <= pin_sample[TONE_W-1:0];
			bank_select_a <= pin_sample[TONE_W];
			bank_select_b <= pin_sample[TONE_W];
		end
	end

	always_comb begin
		alarm_set                  = '0;
		alarm_set[ALM_FIFO_EMPTY]  = fifo_empty_event;
		alarm_set[ALM_FIFO_FULL]   = fifo_full_event;
		alarm_set[ALM_LVDS_CLK]    = lvds_clock_event;
		alarm_set[ALM_LVDS_STROBE] = lvds_strobe_event;
		alarm_set[ALM_TRIG_ALIGN]  = trig_shift;
		alarm_set[ALM_DIV_ALIGN]   = main_shift;
		// capture landed on a position the map marks as risky
		alarm_set[ALM_CLK_ALIGN]   = cap_edge && ref_edge_position_map[capture_select];
	end

	swtc_alarm_flags #(
		.WIDTH(ALARM_W)
	) u_alarms (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.alarm_set  (alarm_set),
		.clear_write(alarm_clear_write),
		.clear_data (alarm_clear_data),
		.alarm_flags(system_alarm_status)
	);

	// pin and mute lag the flags by one cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alarm_pin   <= 1'b0;
			output_mute <= 1'b0;
		end else begin
			alarm_pin   <= |(system_alarm_status & ~alarm_pin_mask);
			output_mute <= mute_on_alarm && (|system_alarm_status);
		end
	end

	property p_map_ends;
		@(posedge sys_clk) disable iff (reset)
		ref_edge_position_map[MAP_LO] && ref_edge_position_map[MAP_HI];
	endproperty
	a_map_ends: assert property (p_map_ends) else $error("map end bit low");

	property p_persist_keep;
		@(posedge sys_clk) disable iff (reset)
		persistence_enable && $past(persistence_enable) |=>
			((ref_edge_position_map & $past(ref_edge_position_map))
			== $past(ref_edge_position_map));
	endproperty
	a_persist_keep: assert property (p_persist_keep) else $error("persisted bit lost");

	property p_map_replace;
		@(posedge sys_clk) disable iff (reset)
		taps_fresh && !persistence_enable |=> ref_edge_position_map == risk_map($past(taps));
	endproperty
	a_map_replace: assert property (p_map_replace) else $error("map not replaced");

	property p_sticky;
		@(posedge sys_clk) disable iff (reset)
		system_alarm_status[ALM_FIFO_FULL] && !(alarm_clear_write
			&& alarm_clear_data[ALM_FIFO_FULL]) |=> system_alarm_status[ALM_FIFO_FULL];
	endproperty
	a_sticky: assert property (p_sticky) else $error("alarm fell without clear");

	property p_clear;
		@(posedge sys_clk) disable iff (reset)
		alarm_clear_write && alarm_clear_data[ALM_LVDS_CLK] && !lvds_clock_event
			|=> !system_alarm_status[ALM_LVDS_CLK];
	endproperty
	a_clear: assert property (p_clear) else $error("alarm clear ignored");

	property p_set_wins;
		@(posedge sys_clk) disable iff (reset)
		fifo_empty_event |=> system_alarm_status[ALM_FIFO_EMPTY];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("alarm event lost");

	property p_pin;
		@(posedge sys_clk) disable iff (reset)
		##1 alarm_pin == |($past(system_alarm_status) & ~$past(alarm_pin_mask));
	endproperty
	a_pin: assert property (p_pin) else $error("alarm pin mismatch");

	property p_mute;
		@(posedge sys_clk) disable iff (reset)
		mute_on_alarm && (|system_alarm_status) |=> output_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("output not muted");

	property p_trig_gate;
		@(posedge sys_clk) disable iff (reset)
		!(trigger_output_enable && oscillator_enable) |=> !trigger_clock_out;
	endproperty
	a_trig_gate: assert property (p_trig_gate) else $error("trigger clock leaked");

	property p_div_reset;
		@(posedge sys_clk) disable iff (reset)
		cap_edge |=> trig_cnt == DIV_PHASE_ZERO ##1 sample_tick;
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider not reset");

	property p_trig_flag;
		@(posedge sys_clk) disable iff (reset)
		cap_edge && !align_enable && !at_wrap(trig_cnt, trig_ratio)
			|=> system_alarm_status[ALM_TRIG_ALIGN];
	endproperty
	a_trig_flag: assert property (p_trig_flag) else $error("trigger flag missing");

	property p_div_flag;
		@(posedge sys_clk) disable iff (reset)
		main_shift |-> !alarm_set[ALM_TRIG_ALIGN] ##1 system_alarm_status[ALM_DIV_ALIGN]
			&& trig_cnt == DIV_PHASE_ZERO;
	endproperty
	a_div_flag: assert property (p_div_flag) else $error("divider flag missing");

	property p_apply;
		@(posedge sys_clk) disable iff (reset)
		trig_rise |=> ##1 tone_select_a == $past(pin_sync[TONE_W-1:0], 2)
			&& bank_select_a == $past(pin_sync[TONE_W], 2)
			&& tone_select_b == tone_select_a && bank_select_a == bank_select_b;
	endproperty
	a_apply: assert property (p_apply) else $error("tone apply mismatch");

	c_persist: cover property (@(posedge sys_clk) disable iff (reset)
		persistence_enable && taps_fresh ##[1:50] taps_fresh);
	c_realign: cover property (@(posedge sys_clk) disable iff (reset) trig_shift);
	c_mute: cover property (@(posedge sys_clk) disable iff (reset)
		output_mute ##[1:20] !output_mute);
endmodule

// >>> test/swtc_refgen.sv
// swtc_refgen: clock generator stand-in that shows one reference pulse on the tap pins.
// assumes a tap at or past the edge position sees the reference high; idle taps read low.
`timescale 1ns/100ps
module swtc_refgen
	import swtc_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             fire,
	input  wire logic [3:0]       coarse_pos,
	input  wire logic [3:0]       fine_pos,
	input  wire logic [3:0]       pulse_len,
	output logic      [MAP_W-1:0] coarse_taps,
	output logic      [MAP_W-1:0] fine_taps
);
	logic [3:0] left;

	// single pulses only, so the continuous-rate limit never applies
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			left <= 4'h0;
		end else if (fire) begin
			left <= pulse_len;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end

	// reference idles low between pulses, so every pulse is a fresh edge
	assign coarse_taps = (left != 4'h0) ? (16'hffff << coarse_pos) : 16'h0000;
	assign fine_taps   = (left != 4'h0) ? (16'hffff << fine_pos) : 16'h0000;
endmodule

// >>> test/swtc_top_bench.sv
// swtc_top_bench: self-checking bench for the reference window and trigger clock block.
// assumes swtc_refgen stands in for the clock generator; every config port is driven here.
`timescale 1ns/100ps
module swtc_top_bench
	import swtc_pkg::*;
;
	logic                sys_clk, reset, fire;
	logic [3:0]          coarse_pos, fine_pos, pulse_len, alarm_events;
	logic [MAP_W-1:0]    coarse_taps, fine_taps, ref_edge_position_map;
	logic                fine_step_select, ref_receiver_sleep, ref_processing_enable;
	logic                persistence_enable, align_enable, trigger_output_enable;
	logic                oscillator_enable, bank_select_input, mute_on_alarm;
	logic                alarm_clear_write, alarm_pin, output_mute, trigger_clock_out;
	logic                bank_select_a, bank_select_b;
	logic [SEL_W-1:0]    capture_select;
	logic [DIV_W-1:0]    trigger_divide_ratio;
	logic [TONE_W-1:0]   tone_select_input, tone_select_a, tone_select_b;
	logic [ALARM_W-1:0]  alarm_pin_mask, alarm_clear_data, system_alarm_status;
	logic [31:0]         hi_cnt;
	int                  num_errors, tests_run, seed;
	int                  pos_list[3] = '{2, 9, 14};
	int                  gap_list[4] = '{40, 43, 51, 40};
	logic                al_list[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	logic [6:0]          flag_list[4] = '{7'h00, 7'h20, 7'h10, 7'h00};
	int                  ratio_list[3] = '{2, 3, 5};
	typedef struct packed {logic [3:0] kind; logic [31:0] val;} swtc_note_t;
	swtc_note_t          notes[$];
	event                note_ev;

	swtc_refgen swtc_refgen_inst (.sys_clk, .reset, .fire, .coarse_pos, .fine_pos, .pulse_len,
		.coarse_taps, .fine_taps);
	swtc_top swtc_top_inst (.sys_clk, .reset, .coarse_taps, .fine_taps, .fine_step_select,
		.ref_receiver_sleep, .ref_processing_enable, .persistence_enable, .align_enable,
		.capture_select, .trigger_divide_ratio, .trigger_output_enable, .oscillator_enable,
		.tone_select_input, .bank_select_input, .fifo_empty_event(alarm_events[0]),
		.fifo_full_event(alarm_events[1]), .lvds_clock_event(alarm_events[2]),
		.lvds_strobe_event(alarm_events[3]), .alarm_pin_mask, .mute_on_alarm,
		.alarm_clear_write, .alarm_clear_data, .ref_edge_position_map, .system_alarm_status,
		.alarm_pin, .output_mute, .trigger_clock_out, .tone_select_a, .tone_select_b,
		.bank_select_a, .bank_select_b);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] observe(input logic [3:0] kind);
		case (kind)
			4'h0: return 32'(ref_edge_position_map);
			4'h1: return 32'(system_alarm_status);
			4'h2: return 32'(alarm_pin);
			4'h3: return 32'(output_mute);
			4'h4: return 32'({tone_select_a, tone_select_b});
			4'h5: return 32'({bank_select_a, bank_select_b});
			4'h6: return 32'(trigger_clock_out);
			default: return hi_cnt;
		endcase
	endfunction

	function automatic logic [15:0] exp_map(input int p);
		return MAP_ENDS | (16'h0003 << (p - 1));
	endfunction

	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic settle();
		tick(2);
		@(negedge sys_clk);
	endtask

	task automatic note_exp(input logic [3:0] kind, input logic [31:0] val);
		notes.push_back('{kind, val});
		-> note_ev;
	endtask

	task automatic fire_ref(input logic [3:0] cpos, input logic [3:0] fpos);
		tick();
		coarse_pos <= cpos;
		fine_pos   <= fpos;
		fire       <= 1'b1;
		tick();
		fire <= 1'b0;
		tick(10);
		@(negedge sys_clk);
	endtask

	// clear strobe and event pins share one edge so set-versus-clear can be forced
	task automatic clear_alarms(input logic [6:0] data, input logic [3:0] evs);
		tick();
		alarm_clear_write <= 1'b1;
		alarm_clear_data  <= data;
		alarm_events      <= evs;
		tick();
		alarm_clear_write <= 1'b0;
		alarm_events      <= 4'h0;
	endtask

	task automatic count_high(input int span);
		hi_cnt = 32'h0000_0000;
		repeat (span) begin
			@(negedge sys_clk);
			hi_cnt = hi_cnt + 32'(trigger_clock_out);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		swtc_note_t n;
		forever begin
			@(note_ev);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				tests_run++;
				if (observe(n.kind) !== n.val) begin
					num_errors++;
					$display("[ERR] t=%0t kind %0h exp %h got %h", $time, n.kind, n.val,
						observe(n.kind));
				end
			end
		end
	end

	// whole sequence needs under 1000 cycles
	initial begin
		#400_000;
		num_errors++;
		give_verdict();
	end

	initial begin
		seed = 32'hd05b_aaf2;
		{reset, ref_processing_enable, mute_on_alarm, pulse_len} = 7'h73;
		{fire, alarm_clear_write, fine_step_select, ref_receiver_sleep, persistence_enable} = '0;
		{align_enable, trigger_output_enable, oscillator_enable, bank_select_input} = '0;
		{coarse_pos, fine_pos, alarm_events, tone_select_input, alarm_pin_mask} = '0;
		{alarm_clear_data, capture_select, trigger_divide_ratio} = {7'h00, 4'h8, 8'h01};
		tick(6);
		reset <= 1'b0;
		@(negedge sys_clk);
		note_exp(0, 32'(MAP_RESET));
		note_exp(1, 32'h0000_0000);
		note_exp(2, 32'h0000_0000);
		$display("test reset done");
		foreach (pos_list[i]) begin
			fire_ref(4'(pos_list[i]), 4'h3);
			note_exp(0, 32'(exp_map(pos_list[i])));
		end
		tick();
		fine_step_select <= 1'b1;
		fire_ref(4'h3, 4'hb);
		note_exp(0, 32'(exp_map(11)));
		tick();
		fine_step_select <= 1'b0;
		fire_ref(4'h5, 4'hb);
		note_exp(0, 32'(exp_map(5)));
		$display("test map done");
		// flags mean nothing until setup is complete, so start from a clean word
		tick();
		capture_select <= 4'h5;
		clear_alarms(7'h7f, 4'h0);
		fire_ref(4'h5, 4'h0);
		note_exp(1, 32'(7'h40));
		note_exp(2, 32'h0000_0001);
		note_exp(3, 32'h0000_0001);
		clear_alarms(7'h7f, 4'h0);
		settle();
		note_exp(3, 32'h0000_0000);
		$display("test capture done");
		tick();
		ref_receiver_sleep <= 1'b1;
		fire_ref(4'hc, 4'h0);
		note_exp(0, 32'(exp_map(5)));
		tick();
		{ref_receiver_sleep, ref_processing_enable} <= 2'b00;
		fire_ref(4'hc, 4'h0);
		note_exp(0, 32'(exp_map(5)));
		tick();
		{ref_processing_enable, persistence_enable, capture_select, pulse_len} <= 10'h387;
		settle();
		note_exp(0, 32'(MAP_RESET));
		fire_ref(4'h3, 4'h0);
		fire_ref(4'ha, 4'h0);
		note_exp(0, 32'(exp_map(3) | exp_map(10)));
		tick();
		{persistence_enable, pulse_len} <= {1'b0, 4'h3};
		fire_ref(4'h6, 4'h0);
		note_exp(0, 32'(exp_map(6)));
		$display("test persistence done");
		for (int k = 0; k < 4; k++) begin
			tick();
			alarm_pin_mask <= 7'($random(seed));
			mute_on_alarm  <= 1'($random(seed));
			clear_alarms(7'h00, 4'h1 << k);
			settle();
			note_exp(1, 32'h0000_0001 << k);
			note_exp(2, 32'(!alarm_pin_mask[k]));
			note_exp(3, 32'(mute_on_alarm));
			clear_alarms(~(7'h01 << k), 4'h0);
			settle();
			note_exp(1, 32'h0000_0001 << k);
			clear_alarms(7'h01 << k, 4'h1 << k);
			settle();
			note_exp(1, 32'h0000_0001 << k);
			clear_alarms(7'h01 << k, 4'h0);
			settle();
			note_exp(1, 32'h0000_0000);
			note_exp(3, 32'h0000_0000);
		end
		$display("test alarms done");
		tick();
		{trigger_divide_ratio, align_enable} <= {8'h08, 1'b1};
		fire_ref(4'h5, 4'h0);
		// fire-to-fire spacing is the gap; main divider runs at 8
		foreach (gap_list[i]) begin
			clear_alarms(7'h7f, 4'h0);
			align_enable <= al_list[i];
			tick(gap_list[i] - 14);
			fire_ref(4'h5, 4'h0);
			note_exp(1, 32'(flag_list[i]));
		end
		$display("test realign done");
		foreach (ratio_list[i]) begin
			for (int en = 0; en < 4; en++) begin
				tick();
				trigger_divide_ratio <= 8'(ratio_list[i]);
				{trigger_output_enable, oscillator_enable} <= 2'(en);
				fire_ref(4'h5, 4'h0);
				count_high(8 * ratio_list[i]);
				note_exp(7, (en == 3) ? 32'(8 * ((ratio_list[i] + 1) / 2)) : 32'h0);
			end
		end
		$display("test trigger clock done");
		repeat (2) begin
			tick();
			{trigger_output_enable, oscillator_enable, trigger_divide_ratio} <= 10'h104;
			tone_select_input <= 4'($random(seed));
			bank_select_input <= 1'($random(seed));
			tick(24);
			@(negedge sys_clk);
			note_exp(4, 32'({tone_select_input, tone_select_input}));
			note_exp(5, 32'({bank_select_input, bank_select_input}));
			note_exp(6, 32'h0000_0000);
		end
		$display("test tone sampling done");
		tick();
		give_verdict();
	end
endmodule
